// *** rtl/counter_pwm.v ***
// one counter-array module in 9/10/11-bit pulse width modulation, with a Wishbone slave
`timescale 1ns/10ps
`include "pwm_consts.vh"
// Operation
// - reload_select 1 maps compare byte accesses to auto-reload, 0 to capture/compare.
// - output goes high when the low N counter bits equal the compare value.
// - output goes low when the counter overflows out of bit N.
// - each overflow sets the cycle overflow flag and reloads compare from auto-reload.
// - N comes from the cycle length select field of the modulator configuration.
// - modulation runs when counter run and modulation enables are set and N is not 8.
// - with match flag and comparator enables set, each match sets the module event flag.
// - overflow recurs every 512, 1024 or 2048 counter clocks for 9, 10, 11 bits.
// - a low compare byte write clears the comparator enable.
// - a high compare byte write sets the comparator enable.
// - duty equals two to the N minus compare, over two to the N.
// - with comparator enable clear the output is held low, zero duty.
module counter_pwm (
  input wire sys_clk,
  input wire reset,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg module_output_pin,
  output wire irq
);

  reg [2:0] module_mode_reg_q;
  reg [3:0] modulator_config_reg_q;
  reg [15:0] compare_q;
  reg [15:0] reload_q;
  reg [15:0] counter_q;
  reg [1:0] status_q; // gathered from the two sticky flag cells
  reg [1:0] irq_en_q;

  wire modulation_enable;
  wire comparator_enable;
  wire match_flag_enable;
  wire [1:0] cycle_length_select;
  wire reload_select;
  wire counter_run;

  assign modulation_enable = module_mode_reg_q[`BIT_MOD_EN];
  assign comparator_enable = module_mode_reg_q[`BIT_CMP_EN];
  assign match_flag_enable = module_mode_reg_q[`BIT_MATCH_EN];
  assign cycle_length_select = modulator_config_reg_q[`CYCLE_LENGTH_SELECT_MSB:`CYCLE_LENGTH_SELECT_LSB];
  assign reload_select = modulator_config_reg_q[`BIT_RELOAD_SEL];
  assign counter_run = modulator_config_reg_q[`BIT_RUN];

  // bus decode: one-cycle answer, misaligned or unknown offsets read zero and ignore writes
  wire req;
  wire wr;
  wire wr_lane0;
  wire wr_lane1;
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i;
  assign wr_lane0 = wr & sel_i[0];
  assign wr_lane1 = wr & sel_i[1];

  wire wr_mode;
  wire wr_config;
  wire wr_cmp_low;
  wire wr_cmp_high;
  wire wr_clear;
  wire wr_irq_en;
  assign wr_mode = wr_lane0 & (adr_i == `OFS_MODE);
  assign wr_config = wr_lane0 & (adr_i == `OFS_CONFIG);
  assign wr_cmp_low = wr_lane0 & (adr_i == `OFS_CMP_LOW);
  assign wr_cmp_high = wr_lane0 & (adr_i == `OFS_CMP_HIGH);
  assign wr_clear = wr_lane0 & (adr_i == `OFS_CLEAR);
  assign wr_irq_en = wr_lane0 & (adr_i == `OFS_IRQ_EN);

  // cycle length mask, 8-bit setting kept for the mask but never runs this mode
  reg [15:0] len_mask;
  always @* begin
    case (cycle_length_select)
      `CYCLE_LENGTH_SELECT_9: len_mask = `MASK_9;
      `CYCLE_LENGTH_SELECT_10: len_mask = `MASK_10;
      `CYCLE_LENGTH_SELECT_11: len_mask = `MASK_11;
      default: len_mask = `MASK_8;
    endcase
  end

  wire long_cycle;
  wire pwm_active;
  assign long_cycle = (cycle_length_select != `CYCLE_LENGTH_SELECT_8);
  // reload keeps running while the comparator is off, so a split write stays glitch free
  assign pwm_active = modulation_enable & long_cycle;

  wire tick;
  wire [15:0] counter_next;
  wire [15:0] low_now;
  wire [15:0] low_next;
  wire overflow;
  assign tick = counter_run;
  assign counter_next = counter_q + `CNT_STEP;
  assign low_now = counter_q & len_mask;
  assign low_next = counter_next & len_mask;
  assign overflow = tick & pwm_active & (low_now == len_mask);

  // the compare seen by the next count already holds the reloaded value
  wire [15:0] compare_eff;
  wire match_next;
  assign compare_eff = overflow ? reload_q : compare_q;
  assign match_next = tick & pwm_active & (low_next == (compare_eff & len_mask));

  // output follows the count: high for counts at or above compare, giving the duty law
  always @(posedge sys_clk) begin
    if (reset) begin
      module_output_pin <= 1'b0;
    end else if (!(pwm_active & comparator_enable)) begin
      module_output_pin <= 1'b0;
    end else if (match_next) begin
      module_output_pin <= 1'b1;
    end else if (overflow) begin
      module_output_pin <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      counter_q <= `RST_CNT;
    end else if (tick) begin
      counter_q <= counter_next;
    end
  end

  // dual-mapped compare bytes: bus write wins over a reload on the byte it writes
  always @(posedge sys_clk) begin
    if (reset) begin
      compare_q <= `RST_CMP;
    end else begin
      if (overflow) begin
        compare_q <= reload_q;
      end
      if (wr_cmp_low & ~reload_select) begin
        compare_q[7:0] <= dat_i[7:0];
      end
      if (wr_cmp_high & ~reload_select) begin
        compare_q[15:8] <= dat_i[7:0];
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      reload_q <= `RST_CMP;
    end else begin
      if (wr_cmp_low & reload_select) begin
        reload_q[7:0] <= dat_i[7:0];
      end
      if (wr_cmp_high & reload_select) begin
        reload_q[15:8] <= dat_i[7:0];
      end
    end
  end

  // compare byte writes touch the comparator enable after any mode write
  always @(posedge sys_clk) begin
    if (reset) begin
      module_mode_reg_q <= `RST_MODE;
    end else begin
      if (wr_mode) begin
        module_mode_reg_q <= dat_i[2:0];
      end
      if (wr_cmp_low) begin
        module_mode_reg_q[`BIT_CMP_EN] <= 1'b0;
      end
      if (wr_cmp_high) begin
        module_mode_reg_q[`BIT_CMP_EN] <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      modulator_config_reg_q <= `RST_CONFIG;
    end else if (wr_config) begin
      modulator_config_reg_q <= dat_i[3:0];
    end
  end

  // sticky flags: a hardware set in the clearing cycle survives
  wire [1:0] flag_set;
  wire [1:0] flag_clr;
  wire [1:0] status_d;
  assign flag_set[`BIT_CYCLE_OVERFLOW_FLAG] = overflow;
  assign flag_set[`BIT_EVENT] = match_next & match_flag_enable & comparator_enable;
  assign flag_clr = wr_clear ? dat_i[1:0] : `RST_FLAGS;

  sticky_flag u_flag_cycle_overflow_flag (
    .sys_clk(sys_clk),
    .reset(reset),
    .set(flag_set[`BIT_CYCLE_OVERFLOW_FLAG]),
    .clr(flag_clr[`BIT_CYCLE_OVERFLOW_FLAG]),
    .flag_q(status_d[`BIT_CYCLE_OVERFLOW_FLAG])
  );

  sticky_flag u_flag_event (
    .sys_clk(sys_clk),
    .reset(reset),
    .set(flag_set[`BIT_EVENT]),
    .clr(flag_clr[`BIT_EVENT]),
    .flag_q(status_d[`BIT_EVENT])
  );

  always @* begin
    status_q = status_d;
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      irq_en_q <= `RST_FLAGS;
    end else if (wr_irq_en) begin
      irq_en_q <= dat_i[1:0];
    end
  end

  assign irq = |(status_q & irq_en_q);

  // read mux: compare bytes follow the selector like writes do
  reg [31:0] rd_data;
  always @* begin
    rd_data = `ZERO_WORD;
    case (adr_i)
      `OFS_MODE: rd_data[2:0] = module_mode_reg_q;
      `OFS_CONFIG: rd_data[3:0] = modulator_config_reg_q;
      `OFS_CMP_LOW: rd_data[7:0] = reload_select ? reload_q[7:0] : compare_q[7:0];
      `OFS_CMP_HIGH: rd_data[7:0] = reload_select ? reload_q[15:8] : compare_q[15:8];
      `OFS_COUNTER: rd_data[15:0] = counter_q;
      `OFS_STATUS: rd_data[1:0] = status_q;
      `OFS_IRQ_EN: rd_data[1:0] = irq_en_q;
      default: rd_data = `ZERO_WORD;
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      ack_o <= 1'b0;
      dat_o <= `ZERO_WORD;
    end else begin
      ack_o <= req;
      if (req & ~we_i) begin
        dat_o <= rd_data;
      end
    end
  end

  // wr_lane1 reserved lane: upper lanes of byte registers are not stored
  wire unused_lane;
  assign unused_lane = wr_lane1;

endmodule // counter_pwm

// one sticky status bit: set by hardware, cleared by software, set wins a tie
module sticky_flag (
  input wire sys_clk,
  input wire reset,
  input wire set,
  input wire clr,
  output reg flag_q
);

  // clearing must never hide an event that lands in the same cycle
  always @(posedge sys_clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule // sticky_flag

// *** common/pwm_consts.vh ***
// register map, field positions and encodings of the counter-array modulator module
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH
`define OFS_MODE 8'h00
`define OFS_CONFIG 8'h04
`define OFS_CMP_LOW 8'h08
`define OFS_CMP_HIGH 8'h0c
`define OFS_COUNTER 8'h10
`define OFS_STATUS 8'h14
`define OFS_CLEAR 8'h18
`define OFS_IRQ_EN 8'h1c
`define BIT_MOD_EN 0
`define BIT_CMP_EN 1
`define BIT_MATCH_EN 2
`define CYCLE_LENGTH_SELECT_LSB 0
`define CYCLE_LENGTH_SELECT_MSB 1
`define BIT_RELOAD_SEL 2
`define BIT_RUN 3
`define BIT_CYCLE_OVERFLOW_FLAG 0
`define BIT_EVENT 1
`define CYCLE_LENGTH_SELECT_8 2'h0
`define CYCLE_LENGTH_SELECT_9 2'h1
`define CYCLE_LENGTH_SELECT_10 2'h2
`define CYCLE_LENGTH_SELECT_11 2'h3
`define MASK_8 16'h00ff
`define MASK_9 16'h01ff
`define MASK_10 16'h03ff
`define MASK_11 16'h07ff
`define CNT_STEP 16'h0001
`define RST_MODE 3'h0
`define RST_CONFIG 4'h0
`define RST_CMP 16'h0000
`define RST_CNT 16'h0000
`define RST_FLAGS 2'h0
`define ZERO_WORD 32'h00000000
`endif

// *** verification/counter_pwm_checker.sv ***
// port-level assertions for the modulator module
`timescale 1ns/10ps
`include "pwm_consts.vh"
module counter_pwm_checker (
  input wire sys_clk,
  input wire reset,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire module_output_pin,
  input wire irq
);
  reg pin_q;
  reg ok_q;
  reg [2:0] quiet_q;
  reg [15:0] gap_q;
  wire wr = ack_o && we_i;
  wire fall = pin_q && !module_output_pin;
  // a fall just after a write may be the enable side effect, not an overflow
  always @(posedge sys_clk) begin
    pin_q <= module_output_pin;
    gap_q <= fall ? 16'h0001 : gap_q + 16'h0001;
    quiet_q <= (reset || wr) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
    ok_q <= (reset || wr) ? 1'b0 : (fall ? quiet_q == 3'h7 : ok_q);
  end
  default clocking @(posedge sys_clk); endclocking
  ack_pulse_a: assert property (disable iff (reset) ack_o |=> !ack_o) else $error("ack too long");
  ack_resp_a: assert property (disable iff (reset) cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  ack_cause_a: assert property (disable iff (reset) ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  rst_out_a: assert property (reset |=> !ack_o && !module_output_pin) else $error("outputs busy in reset");
  rst_irq_a: assert property (reset |=> !irq) else $error("irq in reset");
  cmp_low_a: assert property (disable iff (reset)
    wr && sel_i[0] && adr_i == `OFS_CMP_LOW |=> !module_output_pin) else $error("pin high after low write");
  unmapped_a: assert property (disable iff (reset)
    ack_o && !we_i && adr_i > 8'h1c |-> dat_o == 32'h0) else $error("unmapped read not zero");
  irq_clear_a: assert property (disable iff (reset)
    wr && adr_i == `OFS_IRQ_EN && dat_i[1:0] == 2'h0 |=> !irq) else $error("irq with all enables off");
  period_a: assert property (disable iff (reset)
    fall && ok_q |-> gap_q inside {16'h0200, 16'h0400, 16'h0800}) else $error("bad period");
endmodule // counter_pwm_checker
bind counter_pwm counter_pwm_checker u_chk (.sys_clk(sys_clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .module_output_pin(module_output_pin), .irq(irq));

// *** verification/tb_top.sv ***
// self-checking bench for the modulator module
`timescale 1ns/10ps
`include "pwm_consts.vh"
module tb_top;
  reg sys_clk, reset, cyc_i, stb_i, we_i;
  reg [7:0] adr_i;
  reg [31:0] dat_i, rd;
  wire [31:0] dat_o;
  wire ack_o, module_output_pin, irq;
  integer miscompares, checks, n, hc;
  counter_pwm u_dut (.sys_clk(sys_clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .module_output_pin(module_output_pin), .irq(irq));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge sys_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      for (i = 0; i < 20 && ack_o !== 1'b1; i = i + 1) @(posedge sys_clk);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (i == 20) begin
        $display("[ERR] %0t bus timeout", $time);
        miscompares = miscompares + 1;
        wrap_up;
      end
    end
  endtask
  task high_for(input integer len);
    begin
      hc = 0;
      repeat (len) begin
        @(posedge sys_clk);
        if (module_output_pin === 1'b1) hc = hc + 1;
      end
    end
  endtask
  task t_reset;
    begin
      // the write-only clear register is skipped, 0x20 is unmapped
      for (n = 0; n < 9; n = n + 1) begin
        if (n != 6) wb(1'b0, n * 4, 32'h0);
        if (n != 6) chk(rd, 32'h0);
      end
      $display("reset test done");
    end
  endtask
  task t_duty(input [1:0] cl, input [15:0] c, input integer len);
    begin
      wb(1'b1, `OFS_MODE, 32'h7);
      wb(1'b1, `OFS_CONFIG, {30'h0, cl});
      wb(1'b1, `OFS_CMP_LOW, 32'h0);
      wb(1'b1, `OFS_CMP_HIGH, 32'h0);
      wb(1'b1, `OFS_CONFIG, {30'h1, cl});
      wb(1'b1, `OFS_CMP_LOW, {24'h0, c[7:0]});
      wb(1'b1, `OFS_CMP_HIGH, {24'h0, c[15:8]});
      wb(1'b0, `OFS_CMP_LOW, 32'h0);
      chk(rd, {24'h0, c[7:0]});
      wb(1'b1, `OFS_CONFIG, {30'h2, cl});
      repeat (len + 4) @(posedge sys_clk);
      high_for(len);
      chk(hc, len - c);
      wb(1'b1, `OFS_CONFIG, {30'h0, cl});
      wb(1'b0, `OFS_STATUS, 32'h0);
      chk(rd, 32'h3);
      wb(1'b1, `OFS_CLEAR, 32'h3);
      wb(1'b0, `OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      $display("duty test done");
    end
  endtask
  task t_irq;
    begin
      wb(1'b1, `OFS_IRQ_EN, 32'h0);
      wb(1'b1, `OFS_CONFIG, 32'h9);
      repeat (520) @(posedge sys_clk);
      wb(1'b1, `OFS_CONFIG, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, `OFS_IRQ_EN, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, `OFS_CLEAR, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wb(1'b0, `OFS_IRQ_EN, 32'h0);
      chk(rd, 32'h1);
      $display("irq test done");
    end
  endtask
  task t_enable;
    begin
      wb(1'b1, `OFS_CONFIG, 32'hd);
      wb(1'b1, `OFS_CMP_LOW, 32'h0);
      high_for(512);
      chk(hc, 0);
      wb(1'b1, `OFS_CMP_HIGH, 32'h0);
      repeat (520) @(posedge sys_clk);
      high_for(512);
      chk(hc, 512);
      wb(1'b1, `OFS_CONFIG, 32'h8);
      high_for(256);
      chk(hc, 0);
      $display("enable test done");
    end
  endtask
  initial begin
    miscompares = 0;
    checks = 0;
    reset = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h0;
    dat_i = 32'h0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset;
    t_duty(`CYCLE_LENGTH_SELECT_9, 16'h0100, 512);
    t_duty(`CYCLE_LENGTH_SELECT_10, 16'h0301, 1024);
    t_duty(`CYCLE_LENGTH_SELECT_11, 16'h0005, 2048);
    t_irq;
    t_enable;
    wrap_up;
  end
endmodule // tb_top
